// ==== qdp_params.svh ====
`ifndef QDP_PARAMS_SVH
`define QDP_PARAMS_SVH
// ****************************************
// Register offsets, bank 0 and bank 1
// ****************************************
`define QDP_OFF_RXCMD   4'h2
`define QDP_OFF_RXPTR   4'h6
`define QDP_OFF_QDLOW   4'h8
`define QDP_OFF_QDHIGH  4'hA
`define QDP_OFF_IEN     4'h0
`define QDP_OFF_ISTAT   4'h2
// ****************************************
// Field positions and masks
// ****************************************
`define QDP_BIT_AUTO    14
`define QDP_BIT_RELEASE 0
`define QDP_IEN_MASK    16'hEB80
// ****************************************
// Reset values
// ****************************************
`define QDP_RST_PTR     11'h000
`define QDP_RST_IEN     16'h0000
`define QDP_RST_ISTAT   16'h0300
`endif

// ==== qdp_pkg.sv ====
`default_nettype none
package qdp_pkg;
  typedef logic [10:0] qdp_ptr_t;
  typedef enum logic [1:0] {
    QDP_REL_IDLE  = 2'b00,
    QDP_REL_ISSUE = 2'b01,
    QDP_REL_WAIT  = 2'b10
  } qdp_rel_e;
endpackage
`default_nettype wire

// ==== qdp_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Receive frame side and transmit sink
// ****************************************
module qdp_rx_model
  import qdp_pkg::*;
(
  input  wire logic       clk,      // System clock
  input  wire logic       stall,    // Hold transmit pops
  input  wire logic       rel_req,  // Release pulse
  output var  logic       mem_we,   // Frame memory write
  output var  qdp_ptr_t   mem_addr, // Frame memory address
  output var  logic [7:0] mem_data, // Frame byte
  output var  logic       rel_done, // Release finished
  output var  qdp_ptr_t   rel_addr, // Next frame location
  output var  logic       tx_ready, // Pop transmit word
  output var  logic       filled    // Memory preloaded
);
  qdp_ptr_t next_frame = 11'h123;
  int       delay = 1;
  // Stalls come only from the bench
  assign tx_ready = !stall;
  // Preload after reset; the frame array takes writes even while RESET is high
  initial begin
    filled = 1'b0;
    mem_we = 1'b0;
    repeat (12) @(negedge clk);
    for (int a = 0; a < 2048; a++) begin
      @(negedge clk);
      mem_we = 1'b1;
      mem_addr = a[10:0];
      mem_data = a[7:0] ^ {5'h00, a[10:8]} ^ 8'hA5;
    end
    @(negedge clk);
    mem_we = 1'b0;
    filled = 1'b1;
  end
  // Answer each release after a short, then a long wait
  initial begin
    rel_done = 1'b0;
    rel_addr = 11'h7FF;
    forever begin
      @(negedge clk);
      if (rel_req === 1'b1) begin
        repeat (delay) @(negedge clk);
        rel_addr = next_frame;
        rel_done = 1'b1;
        @(negedge clk);
        rel_done = 1'b0;
        rel_addr = ~next_frame; // Stale location must not be used
        next_frame = next_frame + 11'h2C5;
        delay = 7 - delay;
      end
    end
  end
endmodule
`default_nettype wire

// ==== qdp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "qdp_params.svh"

// ****************************************
// Transmit byte FIFO
// ****************************************
module qdp_fifo #(
  parameter int W = 35,
  parameter int D = 16
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rst,       // Sync reset, high
  input  wire logic         in_valid,  // Push request
  output var  logic         in_ready,  // Room left
  input  wire logic [W-1:0] in_data,   // Pushed word
  output var  logic         out_valid, // Word waiting
  input  wire logic         out_ready, // Pop request
  output var  logic [W-1:0] out_data   // Head word
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;
  wire [CW-1:0]  next_count = count + CW'(push) - CW'(pop);

  // Flags kept as flops so both sides see clean levels
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
      count     <= next_count;
      in_ready  <= next_count != CW'(D);
      out_valid <= next_count != '0;
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
  assign out_data = mem[rd_ptr];
endmodule

// ****************************************
// Queue data port and interrupt enable
// ****************************************
module qdp_top #(
  parameter int RX_BYTES = 2048,
  parameter int TX_DEPTH = 16
) (
  input  wire logic             SYS_CLK,    // 200 MHz clock
  input  wire logic             RESET,      // Sync reset, high
  input  wire logic             BANK18,     // High: bank with enables
  input  wire logic [3:0]       ADDR,       // Doubleword byte address
  input  wire logic [3:0]       BE,         // Byte lane enables
  input  wire logic             WR,         // Write strobe
  input  wire logic             RD,         // Read strobe
  input  wire logic [31:0]      WDATA,      // Write data
  output var  logic [31:0]      RDATA,      // Read data
  output var  logic             RVALID,     // Read data valid
  output var  logic             HOST_READY, // Transmit room
  output var  logic             IRQ_N,      // Interrupt, low
  input  wire logic             RXM_WE,     // Frame memory write
  input  wire qdp_pkg::qdp_ptr_t RXM_ADDR,  // Frame memory address
  input  wire logic [7:0]       RXM_DATA,   // Frame memory byte
  output var  logic             REL_REQ,    // Release pulse
  input  wire logic             REL_DONE,   // Release finished
  input  wire qdp_pkg::qdp_ptr_t REL_ADDR,  // Next frame location
  input  wire logic [6:0]       EVENTS,     // Status set pulses
  output var  logic             TXQ_VALID,  // Transmit word ready
  input  wire logic             TXQ_READY,  // Transmit side takes
  output var  logic [31:0]      TXQ_DATA,   // Packed bytes
  output var  logic [2:0]       TXQ_BYTES   // Valid byte count
);
  import qdp_pkg::*;

  logic [7:0] rx_mem [0:RX_BYTES-1];
  qdp_ptr_t   ptr;
  logic       auto_adv;
  logic [15:0] ien;
  logic [15:0] queue_interrupt_status;
  qdp_rel_e   rel_state;
  qdp_rel_e   next_rel_state;

  // Lowest enabled lane carries the first byte
  function automatic logic [1:0] first_lane(input logic [3:0] be);
    first_lane = be[0] ? 2'd0 : be[1] ? 2'd1 : be[2] ? 2'd2 : 2'd3;
  endfunction

  function automatic logic [2:0] lane_count(input logic [3:0] be);
    lane_count = 3'(be[0]) + 3'(be[1]) + 3'(be[2]) + 3'(be[3]);
  endfunction

  // Hit flag and byte-merged value for a 16-bit register
  function automatic logic [16:0] wr16(input logic [3:0] off,
                                       input logic [3:0] addr,
                                       input logic [3:0] be,
                                       input logic [31:0] wd,
                                       input logic [15:0] old);
    logic [1:0]  b;
    logic [15:0] d;
    b = off[1] ? be[3:2] : be[1:0];
    d = off[1] ? wd[31:16] : wd[15:0];
    wr16 = {(addr[3:2] == off[3:2]) & (|b),
            b[1] ? d[15:8] : old[15:8],
            b[0] ? d[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // Access decode
  // ****************************************
  // Both data halves share one doubleword, so one access moves one byte per enabled lane, up to four
  wire        data_sel = ~BANK18 &
                         (ADDR[3:2] == 2'(`QDP_OFF_QDHIGH >> 2));
  wire [1:0]  fl       = first_lane(BE);
  wire [2:0]  nbytes   = lane_count(BE);
  wire        data_rd  = RD & data_sel & (|BE);
  wire        data_wr  = WR & data_sel & (|BE) & HOST_READY;
  wire [16:0] w_ptr    = wr16(`QDP_OFF_RXPTR, ADDR, BE, WDATA,
                              {1'b0, auto_adv, 3'b000, ptr});
  wire [16:0] w_cmd    = wr16(`QDP_OFF_RXCMD, ADDR, BE, WDATA, 16'h0000);
  wire [16:0] w_ien    = wr16(`QDP_OFF_IEN, ADDR, BE, WDATA, ien);
  wire [16:0] w_isr    = wr16(`QDP_OFF_ISTAT, ADDR, BE, WDATA, 16'h0000);
  wire        ptr_we   = WR & ~BANK18 & w_ptr[16];
  wire        rel_we   = WR & ~BANK18 & w_cmd[16] & w_cmd[`QDP_BIT_RELEASE];
  wire        ien_we   = WR & BANK18 & w_ien[16];
  wire [15:0] isr_clr  = (WR & BANK18 & w_isr[16]) ? w_isr[15:0] : 16'h0;
  wire        reload   = (rel_state == QDP_REL_WAIT) & REL_DONE;

  // ****************************************
  // Receive queue read lanes
  // ****************************************
  // Each lane picks the byte at its distance from the first lane,
  // so any pointer alignment works without host help
  wire [31:0] data_word;
  for (genvar l = 0; l < 4; l++) begin : g_lane
    wire [10:0] a = ptr + 11'(l) - {9'd0, fl};
    assign data_word[8*l +: 8] = BE[l] ? rx_mem[a] : 8'h00;
  end

  // Register views; reserved and unmapped halves read zero
  wire [15:0] ptr_view = {1'b0, auto_adv, 3'b000, ptr};
  wire [15:0] cmd_view = {15'h0000, rel_state != QDP_REL_IDLE};
  wire [3:0]  lo_off   = {ADDR[3:2], 2'b00};
  wire [3:0]  hi_off   = {ADDR[3:2], 2'b10};
  wire [15:0] lo_view  = BANK18 ? (lo_off == `QDP_OFF_IEN ? ien : 16'h0)
                         : (lo_off == `QDP_OFF_RXPTR ? ptr_view : 16'h0);
  wire [15:0] hi_view  = BANK18 ? (hi_off == `QDP_OFF_ISTAT ? queue_interrupt_status : 16'h0)
                         : hi_off == `QDP_OFF_RXPTR ? ptr_view
                         : hi_off == `QDP_OFF_RXCMD ? cmd_view : 16'h0;
  // Data doubleword from receive queue, other doublewords from register views
  wire [31:0] next_rdata = data_sel ? data_word
                         : {hi_view, lo_view};
  wire [15:0] ev_bits  = {EVENTS[6:4], 1'b0, EVENTS[3], 1'b0,
                          EVENTS[2:0], 7'h00};
  // A new event wins over a clear in the same cycle
  wire [15:0] next_isr = (queue_interrupt_status & ~isr_clr) | ev_bits;

  // ****************************************
  // Frame memory fill
  // ****************************************
  always_ff @(posedge SYS_CLK) begin
    if (RXM_WE) rx_mem[RXM_ADDR] <= RXM_DATA;
  end

  // ****************************************
  // Pointer: reload, then host write, then advance
  // ****************************************
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ptr      <= `QDP_RST_PTR;
      auto_adv <= 1'b0;
    end else if (reload) begin
      ptr <= REL_ADDR;
    end else if (ptr_we) begin
      ptr      <= w_ptr[10:0];
      auto_adv <= w_ptr[`QDP_BIT_AUTO];
    end else if (data_rd && auto_adv) begin
      ptr <= ptr + {8'd0, nbytes};
    end
  end

  // Release sequencer: busy bit stays set until the frame is freed
  always_comb begin
    next_rel_state = rel_state;
    case (rel_state)
      QDP_REL_IDLE:  if (rel_we) next_rel_state = QDP_REL_ISSUE;
      QDP_REL_ISSUE: next_rel_state = QDP_REL_WAIT;
      QDP_REL_WAIT:  if (REL_DONE) next_rel_state = QDP_REL_IDLE;
      default:       next_rel_state = QDP_REL_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rel_state <= QDP_REL_IDLE;
      REL_REQ   <= 1'b0;
    end else begin
      rel_state <= next_rel_state;
      REL_REQ   <= next_rel_state == QDP_REL_ISSUE;
    end
  end

  // ****************************************
  // Enables, status, interrupt, read return
  // ****************************************
  // Reserved enable bits never store, so they read zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ien    <= `QDP_RST_IEN;
      queue_interrupt_status    <= `QDP_RST_ISTAT;
      IRQ_N  <= 1'b1;
      RDATA  <= 32'h0000_0000;
      RVALID <= 1'b0;
    end else begin
      if (ien_we) ien <= w_ien[15:0] & `QDP_IEN_MASK;
      queue_interrupt_status    <= next_isr;
      IRQ_N  <= ~|(queue_interrupt_status & ien);
      RDATA  <= RD ? next_rdata : RDATA;
      RVALID <= RD;
    end
  end

  // Writes to the data doubleword go to the transmit FIFO, packed low
  qdp_fifo #(.W(35), .D(TX_DEPTH)) u_txq (
    .clk       (SYS_CLK),
    .rst       (RESET),
    .in_valid  (data_wr),
    .in_ready  (HOST_READY),
    .in_data   ({nbytes, WDATA >> {fl, 3'b000}}),
    .out_valid (TXQ_VALID),
    .out_ready (TXQ_READY),
    .out_data  ({TXQ_BYTES, TXQ_DATA})
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  a_auto_step: assert property (
    data_rd && auto_adv && !reload && !ptr_we
    |=> ptr == $past(ptr) + {8'd0, $past(nbytes)})
    else $error("pointer advance differs from access size");
  a_auto_only: assert property (
    !data_rd && !reload && !ptr_we |=> $stable(ptr))
    else $error("pointer moved without a data read");
  a_no_step: assert property (
    data_rd && !auto_adv && !reload && !ptr_we |=> $stable(ptr))
    else $error("pointer moved with auto advance off");
  a_ptr_reload: assert property (
    reload |=> ptr == $past(REL_ADDR))
    else $error("pointer not reloaded on release");
  a_rel_pulse: assert property (
    rel_state == QDP_REL_IDLE && rel_we
    |=> REL_REQ ##1 (!REL_REQ && rel_state == QDP_REL_WAIT))
    else $error("release request not a single pulse");
  a_irq_level: assert property (
    ##1 IRQ_N == !$past(|(queue_interrupt_status & ien)))
    else $error("interrupt output disagrees with status");
  a_w1c_hold: assert property (
    isr_clr == 16'h0 |=> (queue_interrupt_status & $past(queue_interrupt_status)) == $past(queue_interrupt_status))
    else $error("status bit lost without a clear");
  a_ien_resvd: assert property (
    (ien & ~`QDP_IEN_MASK) == 16'h0)
    else $error("reserved enable bit set");
  a_rd_lane: assert property (
    data_rd && BE[0] |=> RVALID && RDATA[7:0] == $past(rx_mem[ptr]))
    else $error("first data byte not from pointer");

  c_auto_read: cover property (data_rd && auto_adv && BE == 4'hF);
  c_release:   cover property (reload);
  c_irq:       cover property (!IRQ_N);
  c_tx_full:   cover property (!HOST_READY);
endmodule
`default_nettype wire

// ==== qdp_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module qdp_top_tb;
  import qdp_pkg::*;
  // ****************************************
  // Stimulus, model state and observed wires
  // ****************************************
  logic        SYS_CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        BANK18 = 1'b0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        stall = 1'b1;
  logic [3:0]  ADDR = 4'h0;
  logic [3:0]  BE = 4'h0;
  logic [6:0]  EVENTS = 7'h00;
  logic [31:0] WDATA = 32'h0000_0000;
  logic [31:0] RDATA, TXQ_DATA, rd, tx_m;
  logic        RVALID, HOST_READY, IRQ_N, RXM_WE, REL_REQ, REL_DONE;
  logic        TXQ_VALID, TXQ_READY, filled, hr, auto;
  logic [7:0]  RXM_DATA;
  logic [2:0]  TXQ_BYTES;
  qdp_ptr_t    RXM_ADDR, REL_ADDR, ptr, rel_next;
  logic [15:0] lfsr = 16'h000E;
  logic [34:0] tx_exp;
  logic [34:0] transmit_queue[$];
  int          mismatches = 0;
  int          samples_checked = 0;
  int          acc = 0;
  localparam logic [3:0] BES [6] = '{4'h1, 4'h3, 4'hF, 4'hC, 4'h4, 4'h6};
  localparam int POS [7] = '{7, 8, 9, 11, 13, 14, 15};
  qdp_top u_qdp_top (.SYS_CLK(SYS_CLK), .RESET(RESET), .BANK18(BANK18),
    .ADDR(ADDR), .BE(BE), .WR(WR), .RD(RD), .WDATA(WDATA), .RDATA(RDATA),
    .RVALID(RVALID), .HOST_READY(HOST_READY), .IRQ_N(IRQ_N),
    .RXM_WE(RXM_WE), .RXM_ADDR(RXM_ADDR), .RXM_DATA(RXM_DATA),
    .REL_REQ(REL_REQ), .REL_DONE(REL_DONE), .REL_ADDR(REL_ADDR),
    .EVENTS(EVENTS), .TXQ_VALID(TXQ_VALID), .TXQ_READY(TXQ_READY),
    .TXQ_DATA(TXQ_DATA), .TXQ_BYTES(TXQ_BYTES));
  qdp_rx_model u_qdp_rx_model (.clk(SYS_CLK), .stall(stall),
    .rel_req(REL_REQ), .mem_we(RXM_WE), .mem_addr(RXM_ADDR),
    .mem_data(RXM_DATA), .rel_done(REL_DONE), .rel_addr(REL_ADDR),
    .tx_ready(TXQ_READY), .filled(filled));
  // 200 MHz clock
  always #2.5 SYS_CLK = ~SYS_CLK;
  // ****************************************
  // Shared tasks
  // ****************************************
  function automatic logic [15:0] next_rand();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [7:0] pat(qdp_ptr_t a);
    return a[7:0] ^ {5'h00, a[10:8]} ^ 8'hA5;
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One strobe cycle; read data is taken when the strobe drops
  task automatic bus(logic bk, logic [3:0] a, logic [3:0] b, logic w,
                     logic [31:0] d);
    @(negedge SYS_CLK);
    BANK18 = bk;
    ADDR = a;
    BE = b;
    WDATA = d;
    WR = w;
    RD = !w;
    hr = HOST_READY;
    @(negedge SYS_CLK);
    WR = 1'b0;
    RD = 1'b0;
    rd = RDATA;
    if (!w) check("read valid", RVALID, 1);
  endtask
  // Data access at 0x08; lanes packed from the lowest enabled one
  task automatic data(logic w, logic [3:0] b, logic [31:0] d);
    logic [31:0] ev;
    logic [31:0] msk;
    int c;
    ev = 32'h0000_0000;
    msk = 32'h0000_0000;
    c = 0;
    bus(1'b0, 4'h8, b, w, d);
    for (int k = 0; k < 4; k++) begin
      if (b[k] && w) ev[8*c+:8] = d[8*k+:8];
      if (b[k] && !w) ev[8*k+:8] = pat(ptr + c[10:0]);
      if (b[k]) msk[8*k+:8] = 8'hFF;
      if (b[k]) c++;
    end
    if (w && hr) transmit_queue.push_back({c[2:0], ev});
    if (w && hr) acc++;
    if (!w) check("rx data", rd & msk, ev);
    if (!w && auto) ptr = ptr + c[10:0];
  endtask
  task automatic ptr_check();
    bus(1'b0, 4'h4, 4'hC, 1'b0, 32'h0000_0000);
    check("pointer", rd[31:16], {1'b0, auto, 3'b000, ptr});
  endtask
  // Transmit words leave in order with their byte counts
  always @(posedge SYS_CLK) begin
    if (!RESET && TXQ_VALID === 1'b1 && TXQ_READY) begin
      tx_exp = transmit_queue.pop_front();
      tx_m = 32'hFFFF_FFFF >> (8 * (4 - tx_exp[34:32]));
      check("tx bytes", TXQ_BYTES, tx_exp[34:32]);
      check("tx data", TXQ_DATA & tx_m, tx_exp[31:0]);
    end
  end
  // Watchdog far beyond the expected run
  initial begin
    #300_000;
    mismatches++;
    stop_test();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    ptr = 11'h000;
    auto = 1'b0;
    rel_next = 11'h123;
    repeat (10) @(negedge SYS_CLK);
    RESET = 1'b0;
    wait (filled === 1'b1);
    ptr_check();
    bus(1'b1, 4'h0, 4'hF, 1'b0, 32'h0000_0000);
    check("enable reset", rd, 32'h0300_0000);
    bus(1'b0, 4'hC, 4'hF, 1'b0, 32'h0000_0000);
    check("unmapped", rd, 0);
    bus(1'b1, 4'h0, 4'h3, 1'b1, 32'h0000_FFFF);
    bus(1'b1, 4'h0, 4'h3, 1'b0, 32'h0000_0000);
    check("enable mask", rd[15:0], 16'hEB80);
    // Each enable gates only its own source
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, 4'h0, 4'hC, 1'b1, 32'hFFFF_0000);
      bus(1'b1, 4'h0, 4'h3, 1'b1, 32'h1 << POS[i]);
      @(negedge SYS_CLK);
      EVENTS = 7'h01 << ((i + 1) % 7);
      @(negedge SYS_CLK);
      EVENTS = 7'h01 << i;
      @(negedge SYS_CLK);
      EVENTS = 7'h00;
      check("irq masked", IRQ_N, 1);
      repeat (2) @(negedge SYS_CLK);
      check("irq", IRQ_N, 0);
      bus(1'b1, 4'h0, 4'hC, 1'b0, 32'h0000_0000);
      bus(1'b1, 4'h0, 4'hC, 1'b0, 32'h0000_0000);
      check("status kept", rd[POS[i]+16], 1);
      bus(1'b1, 4'h0, 4'hC, 1'b1, 32'h1 << (POS[i] + 16));
      repeat (2) @(negedge SYS_CLK);
      check("irq cleared", IRQ_N, 1);
    end
    // Random mixed accesses at random pointers, auto on and off
    for (int j = 0; j < 64; j++) begin
      if (j % 8 == 0) begin
        auto = j[3];
        ptr = qdp_ptr_t'(next_rand());
        bus(1'b0, 4'h4, 4'hC, 1'b1, {1'b0, auto, 3'b000, ptr, 16'h0000});
      end
      stall = lfsr[1];
      data(lfsr[2], BES[lfsr[5:3] % 6], {next_rand(), next_rand()});
      if (j % 4 == 3) ptr_check();
    end
    // Release reloads the pointer, after a short and a long wait
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, 4'h0, 4'hC, 1'b1, 32'h0001_0000);
      bus(1'b0, 4'h0, 4'hC, 1'b0, 32'h0000_0000);
      check("release busy", rd[16], 1);
      for (int t = 0; t < 20 && rd[16] !== 1'b0; t++) begin
        bus(1'b0, 4'h0, 4'hC, 1'b0, 32'h0000_0000);
      end
      check("release clear", rd[16], 0);
      ptr = rel_next;
      rel_next = rel_next + 11'h2C5;
      ptr_check();
      data(1'b0, 4'hF, 32'h0000_0000);
    end
    // Fill the transmit buffer until it refuses, then drain it
    stall = 1'b0;
    repeat (40) @(negedge SYS_CLK);
    stall = 1'b1;
    acc = 0;
    for (int j = 0; j < 18; j++) data(1'b1, 4'hF, {next_rand(), lfsr});
    check("fifo words", acc, 16);
    check("fifo full", HOST_READY, 0);
    stall = 1'b0;
    repeat (40) @(negedge SYS_CLK);
    check("fifo drained", transmit_queue.size(), 0);
    check("fifo room", HOST_READY, 1);
    stop_test();
  end
endmodule
`default_nettype wire
